//--- pacr_pkg.sv
// Constants and carrier types for the synthesizer analog, charge-pump and
// calibration configuration bank. Assumes a single 40 MHz clock domain.
// Operation
// - Cleared pin enable stops driving the lock/serial output pin completely.
// - Pin enable and general-output bit 7 set: pin driven continuously.
// - Pin enable set, bit 7 clear: serial driver off unless address is 000.
// - Bias enable switches buffer/prescaler bias, only with external oscillator selected.
// - Output level bit: clear selects 1.8 V, set selects 3.3 V level.
// - Down gain field sets down current, 20 uA per code, reset 100.
// - Up gain field sets up current, 20 uA per code, reset 100.
// - Offset magnitude sets offset current, 5 uA per code, reset 81.
// - Separate bits enable up and down offset; reset has only down on.
// - High-gain bit adds 3 mA; only with external oscillator, active filter; the bit is passed to pump_o without gating by ext_osc_sel_i.
// - Resolution code 0-7 selects 1,2,4,8,32,64,128,256 reference cycles; reset 6.
// - Calibration disable bit clear keeps self-calibration on; set suppresses it.
// - Clock select divides reference by 1,4,16,32; reset 1; at most 50 MHz.
// - Auto-relock set: exactly one relock try after lock failure; clear: none.
package pacr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 24;
    localparam logic [3:0] OFS_ANALOG = 4'h8;
    localparam logic [3:0] OFS_PUMP = 4'h9;
    localparam logic [3:0] OFS_CAL = 4'ha;
    localparam logic [23:0] RST_ANALOG = 24'h01bfff;
    localparam logic [23:0] RST_PUMP = 24'h547264;
    localparam logic [23:0] RST_CAL = 24'h002046;
    // Field positions
    localparam int POS_PIN_EN = 5;
    localparam int POS_BIAS_EN = 10;
    localparam int POS_HF_REF = 21;
    localparam int POS_LEVEL = 22;
    localparam int POS_DN_GAIN = 0;
    localparam int POS_UP_GAIN = 7;
    localparam int POS_OFS_MAG = 14;
    localparam int POS_OFS_UP = 21;
    localparam int POS_OFS_DN = 22;
    localparam int POS_HIGH_GAIN = 23;
    localparam int POS_RES = 0;
    localparam int POS_CAL_DIS = 11;
    localparam int POS_CLK_SEL = 13;
    localparam int POS_RELOCK = 17;
    localparam int GENERAL_OUT_BIT = 7;
    localparam logic [2:0] SHARED_ADDR = 3'h0;

    typedef struct packed {
        logic [6:0] down_gain;
        logic [6:0] up_gain;
        logic [6:0] offset_mag;
        logic offset_up;
        logic offset_dn;
        logic high_gain;
    } pacr_pump_t;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RELOCK = 3'b010,
        CAL_SPENT = 3'b100
    } pacr_relock_t;

    typedef struct packed {
        logic [23:0] analog_enable_config;
        logic [23:0] charge_pump_config;
        logic [23:0] vco_calibration_config;
        logic [23:0] rdata;
        pacr_relock_t relock;
        logic [8:0] meas_cycles;
        logic [5:0] cal_div;
        logic pin_oe;
        logic serial_out_driver;
        logic digital_3v_level;
        logic bias_en;
        logic cal_en;
        logic relock_req;
        pacr_pump_t pump;
    } pacr_state_t;
endpackage

//--- pacr_regs.sv
// Configuration bank: three 24-bit registers with decoded analog controls.
// Assumes a plain strobe bus synchronous to clk_i; read data one cycle later.
`timescale 1ns/100ps
module pacr_regs #(
    parameter int ADDR_W = pacr_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [23:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [23:0] rdata_o,
    input wire logic [7:0] general_output_register_i,
    input wire logic [2:0] chip_addr_i,
    input wire logic ext_osc_sel_i,
    input wire logic lock_fail_i,
    output logic lock_serial_out_pin_oe_o,
    output logic serial_out_driver_o,
    output logic digital_3v_level_o,
    output logic high_freq_ref_o,
    output logic bias_en_o,
    output pacr_pkg::pacr_pump_t pump_o,
    output logic [8:0] meas_cycles_o,
    output logic [5:0] cal_clk_div_o,
    output logic cal_en_o,
    output logic relock_req_o
);
    pacr_pkg::pacr_state_t s_reg;
    pacr_pkg::pacr_state_t s_next;
    logic [23:0] a_v;
    logic [23:0] p_v;
    logic [23:0] c_v;

    always_comb begin
        s_next = s_reg;
        s_next.relock_req = 1'b0;
        if (wr_i && addr_i == ADDR_W'(pacr_pkg::OFS_ANALOG)) begin
            s_next.analog_enable_config = wdata_i;
        end
        if (wr_i && addr_i == ADDR_W'(pacr_pkg::OFS_PUMP)) begin
            s_next.charge_pump_config = wdata_i;
        end
        if (wr_i && addr_i == ADDR_W'(pacr_pkg::OFS_CAL)) begin
            s_next.vco_calibration_config = wdata_i;
        end
        s_next.rdata = 24'h000000;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_W'(pacr_pkg::OFS_ANALOG): s_next.rdata = s_reg.analog_enable_config;
                ADDR_W'(pacr_pkg::OFS_PUMP): s_next.rdata = s_reg.charge_pump_config;
                ADDR_W'(pacr_pkg::OFS_CAL): s_next.rdata = s_reg.vco_calibration_config;
                default: s_next.rdata = 24'h000000;
            endcase
        end
        a_v = s_next.analog_enable_config;
        p_v = s_next.charge_pump_config;
        c_v = s_next.vco_calibration_config;
        s_next.pin_oe = 1'b0;
        s_next.serial_out_driver = 1'b0;
        if (a_v[pacr_pkg::POS_PIN_EN]) begin
            if (general_output_register_i[pacr_pkg::GENERAL_OUT_BIT]) begin
                s_next.pin_oe = 1'b1;
            end else begin
                s_next.serial_out_driver = (chip_addr_i == pacr_pkg::SHARED_ADDR);
                s_next.pin_oe = s_next.serial_out_driver;
            end
        end
        s_next.digital_3v_level = a_v[pacr_pkg::POS_LEVEL];
        s_next.bias_en = a_v[pacr_pkg::POS_BIAS_EN] && ext_osc_sel_i;
        s_next.pump.down_gain = p_v[pacr_pkg::POS_DN_GAIN +: 7];
        s_next.pump.up_gain = p_v[pacr_pkg::POS_UP_GAIN +: 7];
        s_next.pump.offset_mag = p_v[pacr_pkg::POS_OFS_MAG +: 7];
        s_next.pump.offset_up = p_v[pacr_pkg::POS_OFS_UP];
        s_next.pump.offset_dn = p_v[pacr_pkg::POS_OFS_DN];
        s_next.pump.high_gain = p_v[pacr_pkg::POS_HIGH_GAIN];
        unique case (c_v[pacr_pkg::POS_RES +: 3])
            3'h0: s_next.meas_cycles = 9'h001;
            3'h1: s_next.meas_cycles = 9'h002;
            3'h2: s_next.meas_cycles = 9'h004;
            3'h3: s_next.meas_cycles = 9'h008;
            3'h4: s_next.meas_cycles = 9'h020;
            3'h5: s_next.meas_cycles = 9'h040;
            3'h6: s_next.meas_cycles = 9'h080;
            3'h7: s_next.meas_cycles = 9'h100;
        endcase
        unique case (c_v[pacr_pkg::POS_CLK_SEL +: 2])
            2'h0: s_next.cal_div = 6'h01;
            2'h1: s_next.cal_div = 6'h04;
            2'h2: s_next.cal_div = 6'h10;
            2'h3: s_next.cal_div = 6'h20;
        endcase
        s_next.cal_en = !c_v[pacr_pkg::POS_CAL_DIS];
        // single relock attempt; re-armed when lock failure clears
        unique case (s_reg.relock)
            pacr_pkg::CAL_IDLE: begin
                if (lock_fail_i && c_v[pacr_pkg::POS_RELOCK]) begin
                    s_next.relock = pacr_pkg::CAL_RELOCK;
                    s_next.relock_req = 1'b1;
                end
            end
            pacr_pkg::CAL_RELOCK: begin
                s_next.relock = pacr_pkg::CAL_SPENT;
            end
            pacr_pkg::CAL_SPENT: begin
                if (!lock_fail_i) begin
                    s_next.relock = pacr_pkg::CAL_IDLE;
                end
            end
            default: s_next.relock = pacr_pkg::CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.analog_enable_config <= pacr_pkg::RST_ANALOG;
            s_reg.charge_pump_config <= pacr_pkg::RST_PUMP;
            s_reg.vco_calibration_config <= pacr_pkg::RST_CAL;
            s_reg.relock <= pacr_pkg::CAL_IDLE;
            s_reg.pump <= '{7'h64, 7'h64, 7'h51, 1'b0, 1'b1, 1'b0};
            s_reg.meas_cycles <= 9'h080;
            s_reg.cal_div <= 6'h04;
            s_reg.cal_en <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign lock_serial_out_pin_oe_o = s_reg.pin_oe;
    assign serial_out_driver_o = s_reg.serial_out_driver;
    assign digital_3v_level_o = s_reg.digital_3v_level;
    assign high_freq_ref_o = s_reg.analog_enable_config[pacr_pkg::POS_HF_REF];
    assign bias_en_o = s_reg.bias_en;
    assign pump_o = s_reg.pump;
    assign meas_cycles_o = s_reg.meas_cycles;
    assign cal_clk_div_o = s_reg.cal_div;
    assign cal_en_o = s_reg.cal_en;
    assign relock_req_o = s_reg.relock_req;
endmodule

//--- pacr_regs_asserts.sv
// Port checker for the configuration bank.
// Assumes one clock clk_i and async active-high rst_i; bound below.
`timescale 1ns/100ps
module pacr_regs_chk #(
    parameter int ADDR_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [23:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [23:0] rdata_o,
    input wire logic [7:0] general_output_register_i,
    input wire logic [2:0] chip_addr_i,
    input wire logic ext_osc_sel_i,
    input wire logic lock_fail_i,
    input wire logic lock_serial_out_pin_oe_o,
    input wire logic serial_out_driver_o,
    input wire logic digital_3v_level_o,
    input wire logic bias_en_o,
    input wire pacr_pkg::pacr_pump_t pump_o,
    input wire logic [8:0] meas_cycles_o,
    input wire logic [5:0] cal_clk_div_o,
    input wire logic cal_en_o,
    input wire logic relock_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire w8 = wr_i && addr_i == pacr_pkg::OFS_ANALOG;
    wire w9 = wr_i && addr_i == pacr_pkg::OFS_PUMP;
    wire wa = wr_i && addr_i == pacr_pkg::OFS_CAL;
    wire [23:0] wp = {wdata_i[6:0], wdata_i[13:7], wdata_i[20:14], wdata_i[21], wdata_i[22], wdata_i[23]};
    // Codes 4..7 skip 16 cycles, hence the extra shift
    wire [3:0] sh = {1'b0, wdata_i[2:0]} + {3'h0, wdata_i[2]};
    wire [1:0] cs = wdata_i[14:13];
    wire [5:0] dv = cs == 2'h0 ? 6'h01 : cs == 2'h1 ? 6'h04 : cs == 2'h2 ? 6'h10 : 6'h20;
    AST_PIN_OFF: assert property (w8 && !wdata_i[5] ##1 !w8 |=> !lock_serial_out_pin_oe_o)
        else $error("pin driven while disabled");
    AST_PIN_GEN_OUT: assert property (w8 && wdata_i[5] ##1 !w8 && general_output_register_i[7] |=> lock_serial_out_pin_oe_o)
        else $error("pin not driven in output mode");
    AST_PIN_SHARED: assert property (w8 && wdata_i[5] ##1 !w8 && !general_output_register_i[7] && chip_addr_i != 3'h0
        |=> !lock_serial_out_pin_oe_o && !serial_out_driver_o)
        else $error("serial driver on for nonzero address");
    AST_BIAS: assert property (!ext_osc_sel_i |=> !bias_en_o)
        else $error("bias on without external oscillator");
    AST_LEVEL: assert property (w8 ##1 !w8 |=> digital_3v_level_o == $past(wdata_i[22], 2))
        else $error("output level wrong");
    AST_PUMP: assert property (w9 ##1 !w9 |=> pump_o == $past(wp, 2))
        else $error("pump fields wrong");
    AST_MEAS: assert property (wa ##1 !wa |=> meas_cycles_o == 9'h001 << $past(sh, 2))
        else $error("measurement length wrong");
    AST_CAL_EN: assert property (wa ##1 !wa |=> cal_en_o == !$past(wdata_i[11], 2))
        else $error("calibration enable wrong");
    AST_DIV: assert property (wa ##1 !wa |=> cal_clk_div_o == $past(dv, 2))
        else $error("clock divide wrong");
    AST_RELOCK_ONE: assert property (relock_req_o |=> !relock_req_o)
        else $error("relock request longer than one cycle");
    AST_RELOCK_CAUSE: assert property ($rose(relock_req_o) |-> $past(lock_fail_i))
        else $error("relock without lock failure");
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 24'h0)
        else $error("read data outside read slot");
endmodule
bind pacr_regs pacr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- tb.sv
// Self-checking bench for the configuration bank.
// Assumes the strobe bus with read data in the cycle after the read.
`timescale 1ns/100ps
module tb;
    logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ext_osc_sel_i = 0, lock_fail_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [23:0] wdata_i = 24'h0, rdata_o, v;
    logic [7:0] general_output_register_i = 8'h00;
    logic [2:0] chip_addr_i = 3'h0;
    logic lock_serial_out_pin_oe_o, serial_out_driver_o, digital_3v_level_o, high_freq_ref_o;
    logic bias_en_o, cal_en_o, relock_req_o;
    pacr_pkg::pacr_pump_t pump_o;
    logic [8:0] meas_cycles_o;
    logic [5:0] cal_clk_div_o;
    logic [8:0] meas_tab [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h020, 9'h040, 9'h080, 9'h100};
    logic [5:0] div_tab [4] = '{6'h01, 6'h04, 6'h10, 6'h20};
    int error_cnt = 0, n_compared = 0;
    logic [23:0] pulses;
    pacr_regs dut (.*);
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [23:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", exp, rdata_o);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    // One loss of lock, counted over eight cycles
    task automatic relock_try(input logic [23:0] exp);
        pulses = 24'h000000;
        @(posedge clk_i);
        lock_fail_i <= 1'b1;
        repeat (8) begin
            @(posedge clk_i);
            // Summing keeps an unknown pulse visible to the compare
            #1 pulses = pulses + 24'(relock_req_o);
        end
        @(posedge clk_i);
        lock_fail_i <= 1'b0;
        chk("relock", exp, pulses);
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h8, 24'h01bfff);
        rd(4'h9, 24'h547264);
        rd(4'ha, 24'h002046);
        chk("pump", {7'h64, 7'h64, 7'h51, 3'h2}, pump_o);
        chk("meas", 24'h000080, 24'(meas_cycles_o));
        chk("div", 24'h000004, 24'(cal_clk_div_o));
        chk("cal_en", 24'h000001, 24'(cal_en_o));
        wr(4'h3, 24'hffffff);
        rd(4'h3, 24'h0);
        v = 24'ha5c3e1;
        wr(4'h9, v);
        rd(4'h9, v);
        chk("pump", {v[6:0], v[13:7], v[20:14], v[21], v[22], v[23]}, pump_o);
        for (int c = 0; c < 8; c++) begin
            v = {6'h00, 1'b1, 2'h0, c[1:0], 1'b0, c[0], 8'h10, c[2:0]};
            wr(4'ha, v);
            settle();
            chk("meas", 24'(meas_tab[c]), 24'(meas_cycles_o));
            chk("div", 24'(div_tab[c[1:0]]), 24'(cal_clk_div_o));
            chk("cal_en", 24'(!c[0]), 24'(cal_en_o));
        end
        for (int p = 0; p < 8; p++) begin
            @(posedge clk_i);
            general_output_register_i <= {p[1], 7'h00};
            chip_addr_i <= p[2] ? 3'h3 : 3'h0;
            ext_osc_sel_i <= p[1];
            wr(4'h8, {1'b0, p[0], p[1], 10'h037, p[2], 4'hf, p[0], 5'h1f});
            settle();
            chk("pin_oe", 24'(p[0] & (p[1] | !p[2])), 24'(lock_serial_out_pin_oe_o));
            chk("serial", 24'(p[0] & !p[1] & !p[2]), 24'(serial_out_driver_o));
            chk("level", 24'(p[0]), 24'(digital_3v_level_o));
            chk("bias", 24'(p[2] & p[1]), 24'(bias_en_o));
            chk("hf_ref", 24'(p[1]), 24'(high_freq_ref_o));
        end
        relock_try(24'h000001);
        relock_try(24'h000001);
        wr(4'ha, 24'h002046);
        relock_try(24'h000000);
        end_sim();
    end
endmodule
